// [hdl/pfdc_top.sv]
// Functional notes
// - Reference divider is 14 bits, ratio 1 to 16383 inclusive.
// - Comparator weighs divided reference against oscillator; drives pump.
// - Phase swap bit exchanges comparator inputs, reversing gain polarity.
// - Force-up bit holds the up output continuously active.
// - Force-down bit holds the down output continuously active.
// - Large phase error under slip guard keeps pump driving correcting way.
// - Slip guard holds correcting polarity until inputs come back into step.
// - Slip guard works only with both enable and output enable bits set.
// - Three-bit reset delay sets how many balanced comparisons release a slip hold.
// - Seven-bit offset magnitude sets a constant pump offset current.
// - Oversized offset may upset lock indication; operator reduces it.
// - Two saturation outputs tell the companion which input leads.
// - Offset joins the up pump or down pump by its select bits.
`default_nettype none
module pfdc_top
  import pfdc_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [pfdc_pkg::APB_AW-1:0] paddr,
  input  wire logic [pfdc_pkg::APB_DW-1:0] pwdata,
  output logic      [pfdc_pkg::APB_DW-1:0] prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     reference_input_pin,
  input  wire logic                     vco_div_in,
  input  wire logic                     slip_req_up,
  input  wire logic                     slip_req_dn,
  output logic                          pump_up,
  output logic                          pump_dn,
  output logic      [pfdc_pkg::OFS_W-1:0] offset_mag,
  output logic                          offset_to_up,
  output logic                          offset_to_dn,
  output logic                          lead_sat_high,
  output logic                          lead_sat_low,
  output logic                          hf_buffer_mode,
  output logic                          slip_guard_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [3:0]           sync1_q, sync2_q, prev_q;
  logic                 ref_edge, vco_edge, req_up, req_dn, ref_tick;
  logic [APB_DW-1:0]    prdata_q, prdata_d, rd_word;
  logic                 pready_q, pready_d, pslverr_q, pslverr_d;
  logic                 mapped, setup, wr_take, ofs_up_wbit;
  logic                 slip_en_q, slip_en_d, slip_oe_q, slip_oe_d;
  logic [REF_DIV_W-1:0] ratio_q, ratio_d;
  logic [DLY_W-1:0]     dly_q, dly_d;
  logic                 swap_q, swap_d, hf_q, hf_d;
  logic [OFS_W-1:0]     ofs_q, ofs_d;
  logic                 ofs_up_q, ofs_up_d, ofs_dn_q, ofs_dn_d;
  logic                 force_up_q, force_up_d, force_dn_q, force_dn_d;
  logic                 a_evt, b_evt, up_n, dn_n, pair_done;
  logic                 up_pend_q, up_pend_d, dn_pend_q, dn_pend_d;
  logic                 sat_up_evt, sat_dn_evt, slip_on, hold_up, hold_dn;
  pfdc_sg_state_t       sg_q, sg_d;
  logic [BAL_W-1:0]     bal_q, bal_d;
  logic                 pump_up_q, pump_up_d, pump_dn_q, pump_dn_d;
  logic                 sath_q, sath_d, satl_q, satl_d;
  logic                 active_q, active_d;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edges are taken only from the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q  <= 4'h0;
    end else begin
      sync1_q <= {slip_req_dn, slip_req_up, vco_div_in, reference_input_pin};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Sampled at 200 MHz, so input edges faster than ~90 MHz may be missed
  assign ref_edge = sync2_q[0] & ~prev_q[0];
  assign vco_edge = sync2_q[1] & ~prev_q[1];
  assign req_up   = sync2_q[2];
  assign req_dn   = sync2_q[3];

  pfdc_ref_div u_ref_div (
    .pclk    (pclk),
    .presetn (presetn),
    .edge_in (ref_edge),
    .ratio   (ratio_q),
    .tick    (ref_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, unmapped addresses answer with pslverr
  always_comb begin
    rd_word = '0;
    if (pfdc_hit(paddr, IDX_CFG1)) begin
      rd_word[SLIP_EN_BIT] = slip_en_q;
      rd_word[SLIP_OE_BIT] = slip_oe_q;
    end else if (pfdc_hit(paddr, IDX_REFDIV)) begin
      rd_word[REF_DIV_W-1:0] = ratio_q;
    end else if (pfdc_hit(paddr, IDX_PDCTL)) begin
      rd_word[DLY_LSB +: DLY_W] = dly_q;
      rd_word[SWAP_BIT]         = swap_q;
    end else if (pfdc_hit(paddr, IDX_PUMP)) begin
      rd_word[OFS_LSB +: OFS_W] = ofs_q;
      rd_word[OFS_UP_BIT]       = ofs_up_q;
      rd_word[OFS_DN_BIT]       = ofs_dn_q;
      rd_word[FORCE_UP_BIT]     = force_up_q;
      rd_word[FORCE_DN_BIT]     = force_dn_q;
    end else if (pfdc_hit(paddr, IDX_BUF)) begin
      rd_word[HF_BIT] = hf_q;
    end else if (pfdc_hit(paddr, IDX_STAT)) begin
      rd_word[ST_UP_BIT]   = pump_up_q;
      rd_word[ST_DN_BIT]   = pump_dn_q;
      rd_word[ST_SATH_BIT] = sath_q;
      rd_word[ST_SATL_BIT] = satl_q;
      rd_word[ST_HOLD_BIT] = active_q;
    end
  end

  assign mapped      = pfdc_hit(paddr, IDX_CFG1) || pfdc_hit(paddr, IDX_REFDIV)
                    || pfdc_hit(paddr, IDX_PDCTL) || pfdc_hit(paddr, IDX_PUMP)
                    || pfdc_hit(paddr, IDX_BUF)   || pfdc_hit(paddr, IDX_STAT);
  assign setup       = psel & ~penable;
  assign wr_take     = psel & penable & pready_q & pwrite & mapped;
  assign ofs_up_wbit = pwdata[OFS_UP_BIT];

  // Register next values; answers are prepared in the setup cycle
  always_comb begin
    pready_d   = setup;
    pslverr_d  = setup & ~mapped;
    prdata_d   = setup ? rd_word : prdata_q;
    slip_en_d  = slip_en_q;
    slip_oe_d  = slip_oe_q;
    ratio_d    = ratio_q;
    dly_d      = dly_q;
    swap_d     = swap_q;
    ofs_d      = ofs_q;
    ofs_up_d   = ofs_up_q;
    ofs_dn_d   = ofs_dn_q;
    force_up_d = force_up_q;
    force_dn_d = force_dn_q;
    hf_d       = hf_q;
    if (wr_take) begin
      if (pfdc_hit(paddr, IDX_CFG1)) begin
        slip_en_d = pwdata[SLIP_EN_BIT];
        slip_oe_d = pwdata[SLIP_OE_BIT];
      end
      if (pfdc_hit(paddr, IDX_REFDIV)) begin
        ratio_d = pwdata[REF_DIV_W-1:0];
      end
      if (pfdc_hit(paddr, IDX_PDCTL)) begin
        dly_d  = pwdata[DLY_LSB +: DLY_W];
        swap_d = pwdata[SWAP_BIT];
      end
      if (pfdc_hit(paddr, IDX_PUMP)) begin
        ofs_d      = pwdata[OFS_LSB +: OFS_W];
        ofs_up_d   = pwdata[OFS_UP_BIT];
        ofs_dn_d   = pwdata[OFS_DN_BIT];
        force_up_d = pwdata[FORCE_UP_BIT];
        force_dn_d = pwdata[FORCE_DN_BIT];
      end
      if (pfdc_hit(paddr, IDX_BUF)) begin
        hf_d = pwdata[HF_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      prdata_q   <= '0;
      slip_en_q  <= 1'b0;
      slip_oe_q  <= 1'b0;
      ratio_q    <= REF_DIV_RST;
      dly_q      <= DLY_RST;
      swap_q     <= 1'b0;
      ofs_q      <= OFS_RST;
      ofs_up_q   <= 1'b0;
      ofs_dn_q   <= 1'b0;
      force_up_q <= 1'b0;
      force_dn_q <= 1'b0;
      hf_q       <= 1'b0;
    end else begin
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      prdata_q   <= prdata_d;
      slip_en_q  <= slip_en_d;
      slip_oe_q  <= slip_oe_d;
      ratio_q    <= ratio_d;
      dly_q      <= dly_d;
      swap_q     <= swap_d;
      ofs_q      <= ofs_d;
      ofs_up_q   <= ofs_up_d;
      ofs_dn_q   <= ofs_dn_d;
      force_up_q <= force_up_d;
      force_dn_q <= force_dn_d;
      hf_q       <= hf_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase comparator, slip guard and pump drive
  always_comb begin
    a_evt      = swap_q ? vco_edge : ref_tick;
    b_evt      = swap_q ? ref_tick : vco_edge;
    up_n       = up_pend_q | a_evt;
    dn_n       = dn_pend_q | b_evt;
    pair_done  = up_n & dn_n;
    up_pend_d  = up_n & ~pair_done;
    dn_pend_d  = dn_n & ~pair_done;
    // A second edge on one side before the other arrives is a slip
    sat_up_evt = a_evt & up_pend_q & ~b_evt;
    sat_dn_evt = b_evt & dn_pend_q & ~a_evt;
    slip_on    = slip_en_q & slip_oe_q;
    hold_up    = (sg_q == SG_HOLD_UP);
    hold_dn    = (sg_q == SG_HOLD_DN);
    sg_d       = sg_q;
    bal_d      = bal_q;
    unique case (sg_q)
      SG_IDLE: begin
        bal_d = BAL_RST;
        if (slip_on && (sat_up_evt || req_up)) begin
          sg_d = SG_HOLD_UP;
        end else if (slip_on && (sat_dn_evt || req_dn)) begin
          sg_d = SG_HOLD_DN;
        end
      end
      SG_HOLD_UP, SG_HOLD_DN: begin
        if (!slip_on) begin
          sg_d = SG_IDLE;
        end else if (hold_up ? (sat_up_evt || req_up)
                             : (sat_dn_evt || req_dn)) begin
          bal_d = BAL_RST;
        end else if (pair_done) begin
          // Release after delay+1 balanced comparisons in a row
          if (bal_q == {1'b0, dly_q}) begin
            sg_d = SG_IDLE;
          end else begin
            bal_d = bal_q + 4'h1;
          end
        end
      end
    endcase
    // Forced bits win over both normal pulses and the slip guard
    pump_up_d = force_up_q | hold_up | (up_pend_d & ~hold_dn);
    pump_dn_d = force_dn_q | hold_dn | (dn_pend_d & ~hold_up);
    sath_d    = sat_up_evt | (sath_q & ~sat_dn_evt & ~pair_done);
    satl_d    = sat_dn_evt | (satl_q & ~sat_up_evt & ~pair_done);
    active_d  = (sg_d != SG_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_pend_q <= 1'b0;
      dn_pend_q <= 1'b0;
      sg_q      <= SG_IDLE;
      bal_q     <= BAL_RST;
      pump_up_q <= 1'b0;
      pump_dn_q <= 1'b0;
      sath_q    <= 1'b0;
      satl_q    <= 1'b0;
      active_q  <= 1'b0;
    end else begin
      up_pend_q <= up_pend_d;
      dn_pend_q <= dn_pend_d;
      sg_q      <= sg_d;
      bal_q     <= bal_d;
      pump_up_q <= pump_up_d;
      pump_dn_q <= pump_dn_d;
      sath_q    <= sath_d;
      satl_q    <= satl_d;
      active_q  <= active_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops
  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign pump_up           = pump_up_q;
  assign pump_dn           = pump_dn_q;
  // Too large a value can upset lock indication downstream
  assign offset_mag        = ofs_q;
  assign offset_to_up      = ofs_up_q;
  assign offset_to_dn      = ofs_dn_q;
  assign lead_sat_high     = sath_q;
  assign lead_sat_low      = satl_q;
  assign hf_buffer_mode    = hf_q;
  assign slip_guard_active = active_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pump_wr;
    wr_take && pfdc_hit(paddr, IDX_PUMP);
  endsequence

  sequence s_release_up;
    hold_up && slip_on && !sat_up_evt && !req_up && pair_done
      && (bal_q == {1'b0, dly_q});
  endsequence

  AST_FORCE_UP: assert property (force_up_q |=> pump_up_q)
    else $error("forced up did not hold the up output");
  AST_FORCE_DN: assert property (force_dn_q |=> pump_dn_q)
    else $error("forced down did not hold the down output");
  AST_DIV_ONE: assert property ((ratio_q == 14'h0001) && ref_edge
                                |=> ref_tick)
    else $error("divide by one missed a reference edge");
  AST_UP_PEND: assert property (a_evt && !b_evt && !up_pend_q && !dn_pend_q
                                |=> up_pend_q && !dn_pend_q)
    else $error("comparator did not register a leading edge");
  AST_SWAP: assert property (swap_q && ref_tick && !vco_edge && !up_pend_q
                             && !dn_pend_q |=> dn_pend_q)
    else $error("swap did not route reference to the down side");
  AST_SLIP_GATE: assert property (!slip_on |=> sg_q == SG_IDLE)
    else $error("slip guard held while not enabled");
  AST_HOLD_UP: assert property (hold_up && !force_dn_q
                                |=> pump_up_q && !pump_dn_q)
    else $error("slip hold did not drive the up pump alone");
  AST_RELEASE: assert property (s_release_up |=> sg_q == SG_IDLE)
    else $error("slip hold not released after balanced cycles");
  AST_SAT_HIGH: assert property (sat_up_evt |=> lead_sat_high ##0
                                 slip_guard_active == $past(slip_on)
                                 || !slip_on)
    else $error("saturation flag missing after a slip");
  AST_OFS_SEL: assert property (s_pump_wr |=>
                                offset_to_up == $past(ofs_up_wbit))
    else $error("offset select did not follow the write");

endmodule
`default_nettype wire

// [hdl/pfdc_pkg.sv]
`default_nettype none
package pfdc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry: each register index sits at byte address index * 4
  localparam int               APB_AW       = 12;
  localparam int               APB_DW       = 32;

  // Register indices
  localparam logic [7:0]       IDX_CFG1     = 8'h01;
  localparam logic [7:0]       IDX_REFDIV   = 8'h02;
  localparam logic [7:0]       IDX_PDCTL    = 8'h03;
  localparam logic [7:0]       IDX_PUMP     = 8'h04;
  localparam logic [7:0]       IDX_BUF      = 8'h08;
  localparam logic [7:0]       IDX_STAT     = 8'h0c;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and widths
  localparam int               SLIP_EN_BIT  = 4;
  localparam int               SLIP_OE_BIT  = 13;
  localparam int               REF_DIV_W    = 14;
  localparam int               DLY_LSB      = 0;
  localparam int               DLY_W        = 3;
  localparam int               SWAP_BIT     = 4;
  localparam int               OFS_LSB      = 14;
  localparam int               OFS_W        = 7;
  localparam int               OFS_UP_BIT   = 21;
  localparam int               OFS_DN_BIT   = 22;
  localparam int               FORCE_UP_BIT = 26;
  localparam int               FORCE_DN_BIT = 27;
  localparam int               HF_BIT       = 11;
  localparam int               BAL_W        = 4;

  // Status word bit positions
  localparam int               ST_UP_BIT    = 0;
  localparam int               ST_DN_BIT    = 1;
  localparam int               ST_SATH_BIT  = 2;
  localparam int               ST_SATL_BIT  = 3;
  localparam int               ST_HOLD_BIT  = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [REF_DIV_W-1:0] REF_DIV_RST = 14'h0001;
  localparam logic [DLY_W-1:0]     DLY_RST     = 3'h0;
  localparam logic [OFS_W-1:0]     OFS_RST     = 7'h00;
  localparam logic [BAL_W-1:0]     BAL_RST     = 4'h0;

  // Slip guard hold states
  typedef enum logic [1:0] {
    SG_IDLE,
    SG_HOLD_UP,
    SG_HOLD_DN
  } pfdc_sg_state_t;

  // Word address match against a register index
  function automatic logic pfdc_hit(input logic [APB_AW-1:0] addr,
                                    input logic [7:0]        idx);
    return addr[APB_AW-1:2] == {2'b00, idx};
  endfunction

endpackage
`default_nettype wire

// [hdl/pfdc_ref_div.sv]
`default_nettype none
module pfdc_ref_div
  import pfdc_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 edge_in,
  input  wire logic [REF_DIV_W-1:0] ratio,
  output logic                      tick
);

  logic [REF_DIV_W-1:0] cnt_q;
  logic [REF_DIV_W-1:0] cnt_d;
  logic                 tick_q;
  logic                 tick_d;
  logic                 last;

  ////////////////////////////////////////////////////////////////////////////
  // Count reference edges; ratio 0 behaves as 1 so the clock never stops
  always_comb begin
    last   = (ratio <= REF_DIV_RST) || (cnt_q >= ratio - REF_DIV_RST);
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (edge_in) begin
      if (last) begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d  = cnt_q + REF_DIV_RST;
      end
    end
  end

  // Registering the tick keeps the comparator input glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule
`default_nettype wire

// [tb/pfdc_companion_model.sv]
`default_nettype none
module pfdc_companion_model (
  input  wire logic        run,
  input  wire logic [15:0] half_ns,
  input  wire logic [15:0] lag_ns,
  input  wire logic        hold_up_cmd,
  input  wire logic        hold_dn_cmd,
  output logic             vco_div_in,
  output logic             slip_req_up,
  output logic             slip_req_dn
);
  timeunit 1ns;
  timeprecision 1ps;

  //////////////////////////////////////////////////////////////////////////
  // Divided oscillator; idles low and always ends a whole period, so a stop
  // never leaves a stray half edge behind for the comparator
  initial begin
    vco_div_in = 1'b0;
    forever begin
      @(posedge run);
      #(lag_ns + 1); // Off the clock edge, no sampling race
      while (run) begin
        vco_div_in = 1'b1;
        #(half_ns);
        vco_div_in = 1'b0;
        #(half_ns);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Hold requests are plain levels, raised only when the bench asks
  assign slip_req_up = hold_up_cmd;
  assign slip_req_dn = hold_dn_cmd;

endmodule
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
`define CHK(nm, got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("ERROR %s expected %0h got %0h", nm, exp, got); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pfdc_pkg::*;

  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ref_pin;
  logic        vco;
  logic        run;
  logic        up_cmd;
  logic        dn_cmd;
  logic        sreq_up;
  logic        sreq_dn;
  logic        pump_up;
  logic        pump_dn;
  logic [6:0]  ofs_mag;
  logic        ofs_up;
  logic        ofs_dn;
  logic        sat_h;
  logic        sat_l;
  logic        hf;
  logic        guard;
  logic [15:0] ref_half;
  logic [15:0] vco_half;
  logic [15:0] lag;
  logic [31:0] rd;
  logic        er;
  int          err_total;
  int          n_tests;
  int          c_up;
  int          c_dn;
  int          c_sh;
  int          c_sl;
  int          c_hold;
  int          c_bad;
  int          c_edge;
  logic [7:0]  idx   [5] = '{IDX_CFG1, IDX_REFDIV, IDX_PDCTL, IDX_PUMP,
                             IDX_BUF};
  logic [31:0] rst_v [5] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
  logic [31:0] msk_v [5] = '{32'h0000_2010, 32'h0000_3fff, 32'h0000_0017,
                             32'h0c7f_c000, 32'h0000_0800};

  //////////////////////////////////////////////////////////////////////////
  // Design and far side
  pfdc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_input_pin(ref_pin), .vco_div_in(vco),
    .slip_req_up(sreq_up), .slip_req_dn(sreq_dn), .pump_up(pump_up),
    .pump_dn(pump_dn), .offset_mag(ofs_mag), .offset_to_up(ofs_up),
    .offset_to_dn(ofs_dn), .lead_sat_high(sat_h), .lead_sat_low(sat_l),
    .hf_buffer_mode(hf), .slip_guard_active(guard));
  pfdc_companion_model i_comp (.run(run), .half_ns(vco_half),
    .lag_ns(lag), .hold_up_cmd(up_cmd), .hold_dn_cmd(dn_cmd),
    .vco_div_in(vco), .slip_req_up(sreq_up), .slip_req_dn(sreq_dn));

  //////////////////////////////////////////////////////////////////////////
  // Clock and reference source, both edges kept clear of pclk edges
  always #2.5 pclk = ~pclk;
  initial begin
    ref_pin = 1'b0;
    forever begin
      @(posedge run);
      #1;
      while (run) begin
        ref_pin = 1'b1;
        #(ref_half);
        ref_pin = 1'b0;
        #(ref_half);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [11:0] ra(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  // One APB transfer; waits on pready, never on a fixed count, then lets
  // one idle edge pass so the next setup never rewrites psel in this step
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) err_total++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic osc(input logic [15:0] rh, vh, lg);
    ref_half <= rh;
    vco_half <= vh;
    lag <= lg;
    run <= 1'b1;
    @(posedge pclk);
  endtask

  // Stop right after a divided oscillator edge so both sides end evenly
  task automatic stp();
    @(posedge vco);
    @(posedge pclk);
    run <= 1'b0;
    repeat (200) @(posedge pclk);
  endtask

  // Counts pump activity over a window of clock cycles
  task automatic watch(input int cyc);
    logic prev;
    prev = 1'b0;
    c_up = 0;
    c_dn = 0;
    c_sh = 0;
    c_sl = 0;
    c_hold = 0;
    c_bad = 0;
    c_edge = 0;
    repeat (cyc) begin
      @(posedge pclk);
      c_up += int'(pump_up === 1'b1);
      c_dn += int'(pump_dn === 1'b1);
      c_sh += int'(sat_h === 1'b1);
      c_sl += int'(sat_l === 1'b1);
      c_hold += int'(guard === 1'b1);
      c_edge += int'((pump_up | pump_dn) === 1'b1 && !prev);
      prev = (pump_up | pump_dn) === 1'b1;
      if (guard === 1'b1 && !(pump_up === 1'b1 || pump_dn === 1'b1)) c_bad++;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Watchdog, well beyond the roughly 30 us the sequence needs
  initial begin
    #200us;
    err_total++;
    summarize();
  end

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {psel, penable, pwrite, run, up_cmd, dn_cmd} = '0;
    {paddr, pwdata, ref_half, vco_half, lag} = '0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, then writable bits of each register except status
    for (int i = 0; i < 5; i++) begin
      apb(ra(idx[i]), 1'b0, '0);
      `CHK("reset value", rd, rst_v[i])
      apb(ra(idx[i]), 1'b1, 32'hffff_ffff);
      apb(ra(idx[i]), 1'b0, '0);
      `CHK("writable bits", rd, msk_v[i])
    end
    apb(12'h03c, 1'b1, 32'hffff_ffff);
    apb(12'h03c, 1'b0, '0);
    `CHK("unmapped error", er, 1'b1)
    `CHK("unmapped data", rd, 32'h0)
    // Everything set: both forced, offset full scale to both pumps
    repeat (2) @(posedge pclk);
    `CHK("force up", pump_up, 1'b1)
    `CHK("force dn", pump_dn, 1'b1)
    `CHK("offset", {ofs_mag, ofs_up, ofs_dn}, 9'h1ff)
    `CHK("hf mode", hf, 1'b1)
    apb(ra(IDX_STAT), 1'b0, '0);
    `CHK("status pumps", rd[1:0], 2'b11)
    apb(ra(IDX_PUMP), 1'b1, 32'h0028_0000);
    repeat (2) @(posedge pclk);
    `CHK("offset up", {ofs_mag, ofs_up, ofs_dn}, 9'h082)
    `CHK("force released", pump_up, 1'b0)
    apb(ra(IDX_PUMP), 1'b1, 32'h0048_0000);
    repeat (2) @(posedge pclk);
    `CHK("offset dn", {ofs_mag, ofs_up, ofs_dn}, 9'h081)
    apb(ra(IDX_PUMP), 1'b1, 32'h0);
    apb(ra(IDX_CFG1), 1'b1, 32'h0);
    apb(ra(IDX_PDCTL), 1'b1, 32'h0);
    apb(ra(IDX_REFDIV), 1'b1, 32'h1);
    // Reference leads by 5 cycles: up pulses only
    osc(16'd50, 16'd50, 16'd25);
    watch(100);
    watch(400);
    `CHK("lead up", c_up inside {[80:120]}, 1'b1)
    `CHK("lead dn", c_dn, 0)
    // Swapped inputs reverse the polarity
    apb(ra(IDX_PDCTL), 1'b1, 32'h10);
    watch(100);
    watch(400);
    `CHK("swap dn", c_dn inside {[80:120]}, 1'b1)
    `CHK("swap up", c_up, 0)
    // Forced outputs win over running comparator pulses
    apb(ra(IDX_PUMP), 1'b1, 32'h0400_0000);
    watch(4);
    watch(200);
    `CHK("forced up run", c_up, 200)
    apb(ra(IDX_PUMP), 1'b1, 32'h0800_0000);
    watch(4);
    watch(200);
    `CHK("forced dn run", c_dn, 200)
    apb(ra(IDX_PUMP), 1'b1, 32'h0);
    apb(ra(IDX_PDCTL), 1'b1, 32'h3);
    stp();
    // Ratio 4: one comparison per 40 cycles
    apb(ra(IDX_REFDIV), 1'b1, 32'h4);
    osc(16'd25, 16'd100, 16'd25);
    watch(200);
    watch(800);
    `CHK("divided rate", c_edge inside {[19:21]}, 1'b1)
    stp();
    apb(ra(IDX_REFDIV), 1'b1, 32'h1);
    // Enable without output enable: no hold on a fast reference
    apb(ra(IDX_CFG1), 1'b1, 32'h10);
    osc(16'd50, 16'd150, 16'd25);
    watch(400);
    `CHK("guard gated", c_hold, 0)
    // Both enables: slipping starts a hold that keeps a pump on
    apb(ra(IDX_CFG1), 1'b1, 32'h2010);
    watch(400);
    `CHK("sat high seen", c_sh > 0, 1'b1)
    `CHK("hold seen", c_hold > 0, 1'b1)
    `CHK("pump held", c_bad, 0)
    stp();
    osc(16'd50, 16'd50, 16'd25);
    watch(400);
    `CHK("hold released", guard, 1'b0)
    stp();
    // Companion asks a down hold
    dn_cmd <= 1'b1;
    repeat (10) @(posedge pclk);
    `CHK("req hold", guard, 1'b1)
    `CHK("req pump dn", pump_dn, 1'b1)
    apb(ra(IDX_STAT), 1'b0, '0);
    `CHK("status hold dn", rd[4:1], 4'b1001)
    dn_cmd <= 1'b0;
    osc(16'd50, 16'd50, 16'd25);
    watch(400);
    `CHK("req released", guard, 1'b0)
    stp();
    // Oscillator far ahead: the down side slips and holds the down pump
    osc(16'd150, 16'd50, 16'd25);
    watch(400);
    `CHK("sat low seen", c_sl > 0, 1'b1)
    `CHK("hold dn seen", c_hold > 0, 1'b1)
    `CHK("pump held dn", c_bad, 0)
    stp();
    // Reset in mid-run clears the hold and the registers
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("mid reset pins", {guard, sat_l, pump_dn}, 3'b000)
    apb(ra(IDX_CFG1), 1'b0, '0);
    `CHK("mid reset cfg", rd, 32'h0)
    // Companion asks an up hold
    apb(ra(IDX_CFG1), 1'b1, 32'h2010);
    up_cmd <= 1'b1;
    repeat (10) @(posedge pclk);
    `CHK("req pump up", {guard, pump_up, pump_dn}, 3'b110)
    summarize();
  end

endmodule
`default_nettype wire
